/* File: rtl/swm_pkg.sv */
package swm_pkg;

	// ************************************************************
	// Frame lengths and timing
	// ************************************************************
	localparam int unsigned SWM_CNT_W = 6;
	localparam logic [5:0] SWM_LEN_8 = 6'h08;
	localparam logic [5:0] SWM_LEN_16 = 6'h10;
	localparam logic [5:0] SWM_LEN_24 = 6'h18;
	localparam logic [5:0] SWM_LEN_CRC = 6'h08;
	localparam logic [5:0] SWM_LEN_STAT = 6'h08;
	localparam logic [5:0] SWM_CNT_RST = 6'h00;
	localparam int unsigned SWM_CLK_MHZ = 40;
	localparam int unsigned SWM_REL_DELAY_NS = 100;
	localparam int unsigned SWM_REL_DELAY_CYC_RAW = (SWM_REL_DELAY_NS * SWM_CLK_MHZ) / 1000;
	localparam logic [3:0] SWM_REL_DELAY_CYC = (SWM_REL_DELAY_CYC_RAW < 1) ? 4'h1 : 4'(SWM_REL_DELAY_CYC_RAW);
	localparam logic [3:0] SWM_DLY_RST = 4'h0;
	localparam logic [3:0] SWM_DLY_LAST = 4'h1;
	localparam logic [1:0] SWM_PIN_IDLE = 2'h3;

	// ************************************************************
	// Register reset values
	// ************************************************************
	localparam logic SWM_CS_EN_RST = 1'b0;
	localparam logic SWM_REF_EN_RST = 1'b0;
	localparam logic SWM_DLY_EN_RST = 1'b0;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {
		SWM_IDLE = 2'b00,
		SWM_XFER = 2'b01,
		SWM_HOLD = 2'b10
	} swm_state_t;

	typedef struct packed {
		logic cs_en;
		logic dly_en;
		logic ref_en;
		logic ref_sel;
	} swm_cfg_t;

	typedef struct packed {
		logic data;
		logic oe;
	} swm_pin_t;

endpackage : swm_pkg

/* File: rtl/swm_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module swm_sync
	import swm_pkg::*;
#(
	parameter int unsigned W = 3,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// Per-bit two-stage synchroniser
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					meta_ff[g] <= RST_VAL[g];
					sync_ff[g] <= RST_VAL[g];
				end else begin
					meta_ff[g] <= d_i[g];
					sync_ff[g] <= meta_ff[g];
				end
			end
		end
	endgenerate

	assign q_o = sync_ff;
endmodule // swm_sync
`default_nettype wire

/* File: rtl/swm_spi_mode.sv */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - CS disabled: 3-wire, idle on last SCLK rise
// - 3-wire read end: release or show ready
// - Release-delay bit adjusts output release moment
// - 3-wire: CS high tristates output
// - CS enabled: 4-wire, idle on CS rise
// - 4-wire read end: release on CS rise
// - SPI error checks valid only in 4-wire
// - 4-wire: output tristated while CS high
// - CS enable bit R/W, resets 0
// - Reference enable resets off; level follows select
module swm_spi_mode
	import swm_pkg::*;
(
	input wire logic CLK_SYS_I,
	input wire logic NRST_I,
	input wire logic SCLK_I,
	input wire logic CS_N_I,
	input wire logic CHIP_SELECT_PIN_ENABLE_I,
	input wire logic OUTPUT_RELEASE_DELAY_I,
	input wire logic INTERNAL_REFERENCE_ENABLE_I,
	input wire logic INTERNAL_REFERENCE_LEVEL_SELECT_I,
	input wire logic RESERVED_WR_I,
	input wire logic CFG_WE_I,
	input wire logic XFER_START_I,
	input wire logic XFER_READ_I,
	input wire logic [1:0] XFER_SIZE_I,
	input wire logic XFER_CRC_I,
	input wire logic XFER_STAT_I,
	input wire logic TX_BIT_I,
	input wire logic READY_ON_PIN_I,
	input wire logic READY_N_I,
	input wire logic ERR_CHECK_REQ_I,
	output logic CHIP_SELECT_PIN_ENABLE_O,
	output logic INTERNAL_REFERENCE_ENABLE_O,
	output logic INTERNAL_REFERENCE_LEVEL_SELECT_O,
	output logic RESERVED_O,
	output logic REFERENCE_OUTPUT_PIN_O,
	output logic DOUT_O,
	output logic DOUT_OE_O,
	output logic IF_RESET_O,
	output logic SERIAL_CLOCK_COUNT_ERROR_CHECK_O,
	output logic BUSY_O
);
	// ************************************************************
	// Pin synchronisers and edge detection
	// ************************************************************
	logic [1:0] sync_q;
	logic sclk_s;
	logic cs_n_s;
	logic sclk_d_ff;
	logic cs_n_d_ff;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_rise;

	// Reset to idle pin levels so no false edge follows reset
	swm_sync #(.W(2), .RST_VAL(SWM_PIN_IDLE)) u_sync (
		.clk_i(CLK_SYS_I),
		.nrst_i(NRST_I),
		.d_i({SCLK_I, CS_N_I}),
		.q_o(sync_q)
	);
	assign sclk_s = sync_q[1];
	assign cs_n_s = sync_q[0];

	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			sclk_d_ff <= 1'b1;
			cs_n_d_ff <= 1'b1;
		end else begin
			sclk_d_ff <= sclk_s;
			cs_n_d_ff <= cs_n_s;
		end
	end
	assign sclk_rise = sclk_s & ~sclk_d_ff;
	assign sclk_fall = ~sclk_s & sclk_d_ff;
	assign cs_rise = cs_n_s & ~cs_n_d_ff;

	// ************************************************************
	// Configuration bits
	// ************************************************************
	swm_cfg_t cfg_ff;

	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			cfg_ff.cs_en <= SWM_CS_EN_RST;
			cfg_ff.dly_en <= SWM_DLY_EN_RST;
			cfg_ff.ref_en <= SWM_REF_EN_RST;
			cfg_ff.ref_sel <= 1'b0;
		end else if (CFG_WE_I) begin
			cfg_ff.cs_en <= CHIP_SELECT_PIN_ENABLE_I;
			cfg_ff.dly_en <= OUTPUT_RELEASE_DELAY_I;
			cfg_ff.ref_en <= INTERNAL_REFERENCE_ENABLE_I;
			cfg_ff.ref_sel <= INTERNAL_REFERENCE_LEVEL_SELECT_I;
		end
	end

	// Reserved write data deliberately unused
	logic unused_rsvd;
	assign unused_rsvd = RESERVED_WR_I;

	// ************************************************************
	// Frame tracking
	// ************************************************************
	swm_state_t state_ff;
	swm_state_t nxt_state;
	logic [5:0] len_ff;
	logic [5:0] cnt_ff;
	logic rd_ff;
	logic [3:0] dly_ff;
	logic last_rise;
	logic frame_end;
	logic [5:0] nxt_len;

	always_comb begin
		case (XFER_SIZE_I)
			2'd0: nxt_len = SWM_LEN_8;
			2'd1: nxt_len = SWM_LEN_16;
			default: nxt_len = SWM_LEN_24;
		endcase
		// Host must clock exactly this many bits in 3-wire mode
		if (XFER_CRC_I) begin
			nxt_len = 6'(nxt_len + SWM_LEN_CRC);
		end
		if (XFER_STAT_I) begin
			nxt_len = 6'(nxt_len + SWM_LEN_STAT);
		end
	end

	assign last_rise = (state_ff == SWM_XFER) && sclk_rise && (cnt_ff == 6'(len_ff - 6'h01));
	// Mode picks the frame-ending event
	assign frame_end = cfg_ff.cs_en ? cs_rise : last_rise;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			SWM_IDLE: begin
				if (XFER_START_I) begin
					nxt_state = SWM_XFER;
				end
			end
			SWM_XFER: begin
				if (frame_end) begin
					nxt_state = (rd_ff && cfg_ff.dly_en) ? SWM_HOLD : SWM_IDLE;
				end else if (last_rise) begin
					nxt_state = SWM_XFER;
				end
			end
			SWM_HOLD: begin
				if (dly_ff <= SWM_DLY_LAST) begin
					nxt_state = SWM_IDLE;
				end
			end
			default: nxt_state = SWM_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			state_ff <= SWM_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			len_ff <= SWM_LEN_8;
			rd_ff <= 1'b0;
			cnt_ff <= SWM_CNT_RST;
		end else if (state_ff == SWM_IDLE && XFER_START_I) begin
			len_ff <= nxt_len;
			rd_ff <= XFER_READ_I;
			cnt_ff <= SWM_CNT_RST;
		end else if (state_ff == SWM_XFER && sclk_rise && cnt_ff != len_ff) begin
			cnt_ff <= 6'(cnt_ff + 6'h01);
		end
	end

	// Delayed release counts after the frame end
	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			dly_ff <= SWM_DLY_RST;
		end else if (state_ff == SWM_XFER && frame_end) begin
			// Frame end cycle already counts as the first held cycle
			dly_ff <= 4'(SWM_REL_DELAY_CYC - SWM_DLY_LAST);
		end else if (state_ff == SWM_HOLD && dly_ff != SWM_DLY_RST) begin
			dly_ff <= 4'(dly_ff - 4'h1);
		end
	end

	// ************************************************************
	// Shared output pin
	// ************************************************************
	swm_pin_t pin_ff;
	swm_pin_t nxt_pin;
	logic tx_ff;

	// Data changes on SCLK fall so the host samples stable bits
	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			tx_ff <= 1'b0;
		end else if (sclk_fall || (state_ff == SWM_IDLE && XFER_START_I)) begin
			tx_ff <= TX_BIT_I;
		end
	end

	always_comb begin
		nxt_pin.data = 1'b0;
		nxt_pin.oe = 1'b0;
		if (cs_n_s) begin
			nxt_pin.oe = 1'b0;
		end else if ((state_ff == SWM_XFER && rd_ff && (!frame_end || cfg_ff.dly_en)) || state_ff == SWM_HOLD) begin
			nxt_pin.data = tx_ff;
			nxt_pin.oe = 1'b1;
		end else if (READY_ON_PIN_I) begin
			// After a read the pin reverts to ready signalling
			nxt_pin.data = READY_N_I;
			nxt_pin.oe = 1'b1;
		end else begin
			nxt_pin.oe = 1'b0;
		end
	end

	// ************************************************************
	// Registered outputs
	// ************************************************************
	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			pin_ff <= '0;
			IF_RESET_O <= 1'b0;
			BUSY_O <= 1'b0;
			SERIAL_CLOCK_COUNT_ERROR_CHECK_O <= 1'b0;
			REFERENCE_OUTPUT_PIN_O <= 1'b0;
		end else begin
			pin_ff <= nxt_pin;
			IF_RESET_O <= (state_ff == SWM_XFER) && frame_end;
			BUSY_O <= (nxt_state != SWM_IDLE);
			// Error checks meaningless without a CS frame boundary
			SERIAL_CLOCK_COUNT_ERROR_CHECK_O <= ERR_CHECK_REQ_I & cfg_ff.cs_en;
			REFERENCE_OUTPUT_PIN_O <= cfg_ff.ref_en & cfg_ff.ref_sel;
		end
	end

	assign DOUT_O = pin_ff.data;
	assign DOUT_OE_O = pin_ff.oe;
	assign CHIP_SELECT_PIN_ENABLE_O = cfg_ff.cs_en;
	assign INTERNAL_REFERENCE_ENABLE_O = cfg_ff.ref_en;
	assign INTERNAL_REFERENCE_LEVEL_SELECT_O = cfg_ff.ref_sel;
	assign RESERVED_O = 1'b0;
endmodule // swm_spi_mode
`default_nettype wire

/* File: test/swm_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****
// Host master: clock idles high and stands still between frames
// ****
module swm_host_model (
	output var logic sclk_o,
	output var logic cs_n_o
);
	initial begin
		sclk_o = 1'b1;
		cs_n_o = 1'b1;
	end
	// 1 ns skew keeps edges off the system clock edges
	task automatic bits(input int n);
		#1;
		repeat (n) begin
			#100 sclk_o = 1'b0;
			#100 sclk_o = 1'b1;
		end
	endtask
	task automatic sel(input logic v);
		#101 cs_n_o = v;
	endtask
endmodule // swm_host_model
`default_nettype wire

/* File: test/swm_spi_mode_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module swm_spi_mode_sva (
	input wire logic CLK_SYS_I,
	input wire logic NRST_I,
	input wire logic CS_N_I,
	input wire logic CHIP_SELECT_PIN_ENABLE_I,
	input wire logic CFG_WE_I,
	input wire logic READY_ON_PIN_I,
	input wire logic ERR_CHECK_REQ_I,
	input wire logic CHIP_SELECT_PIN_ENABLE_O,
	input wire logic INTERNAL_REFERENCE_ENABLE_O,
	input wire logic INTERNAL_REFERENCE_LEVEL_SELECT_O,
	input wire logic RESERVED_O,
	input wire logic REFERENCE_OUTPUT_PIN_O,
	input wire logic DOUT_OE_O,
	input wire logic IF_RESET_O,
	input wire logic SERIAL_CLOCK_COUNT_ERROR_CHECK_O,
	input wire logic BUSY_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!NRST_I);
	// ****
	// Port checks
	// ****
	a_cs_high_tristate: assert property (CS_N_I [*6] |-> !DOUT_OE_O)
		else $error("pin driven with select high");
	a_cfg_load: assert property (CFG_WE_I |=> CHIP_SELECT_PIN_ENABLE_O == $past(CHIP_SELECT_PIN_ENABLE_I))
		else $error("select enable not loaded");
	a_ref_level: assert property (REFERENCE_OUTPUT_PIN_O == ($past(INTERNAL_REFERENCE_ENABLE_O)
		&& $past(INTERNAL_REFERENCE_LEVEL_SELECT_O))) else $error("reference level wrong");
	a_reserved_zero: assert property (RESERVED_O == 1'b0)
		else $error("reserved not zero");
	a_err_check_gate: assert property (SERIAL_CLOCK_COUNT_ERROR_CHECK_O == ($past(ERR_CHECK_REQ_I)
		&& $past(CHIP_SELECT_PIN_ENABLE_O))) else $error("error check gating wrong");
	a_cs_rise_idle: assert property (CHIP_SELECT_PIN_ENABLE_O && BUSY_O && $rose(CS_N_I)
		|-> ##[2:6] IF_RESET_O) else $error("no reset on select rise");
	a_ifreset_pulse: assert property (IF_RESET_O |=> !IF_RESET_O)
		else $error("interface reset too long");
	a_release_3w: assert property (IF_RESET_O && !READY_ON_PIN_I && !CHIP_SELECT_PIN_ENABLE_O
		|-> ##[0:8] !DOUT_OE_O) else $error("pin not released");
	c_end_3w: cover property (IF_RESET_O && !CHIP_SELECT_PIN_ENABLE_O);
	c_end_4w: cover property (IF_RESET_O && CHIP_SELECT_PIN_ENABLE_O);
	c_ready: cover property (DOUT_OE_O && READY_ON_PIN_I && !BUSY_O);
endmodule // swm_spi_mode_sva
bind swm_spi_mode swm_spi_mode_sva chk_u (.*);
`default_nettype wire

/* File: test/swm_spi_mode_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module swm_spi_mode_tb
	import swm_pkg::*;
;
	logic CLK_SYS_I, NRST_I, CHIP_SELECT_PIN_ENABLE_I, OUTPUT_RELEASE_DELAY_I, INTERNAL_REFERENCE_ENABLE_I;
	logic INTERNAL_REFERENCE_LEVEL_SELECT_I, RESERVED_WR_I, CFG_WE_I, XFER_START_I, XFER_READ_I, XFER_CRC_I;
	logic XFER_STAT_I, TX_BIT_I, READY_ON_PIN_I, READY_N_I, ERR_CHECK_REQ_I, SCLK_I, CS_N_I;
	logic [1:0] XFER_SIZE_I;
	logic CHIP_SELECT_PIN_ENABLE_O, INTERNAL_REFERENCE_ENABLE_O, INTERNAL_REFERENCE_LEVEL_SELECT_O, RESERVED_O;
	logic REFERENCE_OUTPUT_PIN_O, DOUT_O, DOUT_OE_O, IF_RESET_O, SERIAL_CLOCK_COUNT_ERROR_CHECK_O, BUSY_O;
	int mismatches, samples_checked, rsts, r0, held, h0;
	swm_spi_mode dut_u (.*);
	swm_host_model host_u (.sclk_o(SCLK_I), .cs_n_o(CS_N_I));
	// ****
	// Helpers
	// ****
	initial begin
		CLK_SYS_I = 1'b0;
		forever #12.5 CLK_SYS_I = ~CLK_SYS_I;
	end
	always @(posedge CLK_SYS_I) rsts <= rsts + IF_RESET_O;
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic cfg(input logic cs, dly, en, lvl);
		@(posedge CLK_SYS_I);
		{CHIP_SELECT_PIN_ENABLE_I, OUTPUT_RELEASE_DELAY_I} <= {cs, dly};
		{INTERNAL_REFERENCE_ENABLE_I, INTERNAL_REFERENCE_LEVEL_SELECT_I, CFG_WE_I} <= {en, lvl, 1'b1};
		@(posedge CLK_SYS_I);
		CFG_WE_I <= 1'b0;
		repeat (3) @(posedge CLK_SYS_I);
	endtask
	task automatic start(input logic [1:0] sz, input logic ext);
		@(posedge CLK_SYS_I);
		{XFER_START_I, XFER_SIZE_I, XFER_CRC_I, XFER_STAT_I} <= {1'b1, sz, ext, ext};
		@(posedge CLK_SYS_I);
		XFER_START_I <= 1'b0;
	endtask
	// Holds back the last clock to catch an early frame end
	task automatic read3(input logic [1:0] sz, input logic ext, input int n);
		start(sz, ext);
		r0 = rsts;
		host_u.bits(n - 1);
		#400;
		cmp("early end", 8'h00, 8'(rsts - r0));
		host_u.bits(1);
		held = 0;
		repeat (16) @(posedge CLK_SYS_I) held += DOUT_OE_O;
		cmp("frame end", 8'h01, 8'(rsts - r0));
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ****
	// Tests
	// ****
	initial begin
		{NRST_I, CHIP_SELECT_PIN_ENABLE_I, OUTPUT_RELEASE_DELAY_I, INTERNAL_REFERENCE_ENABLE_I, CFG_WE_I} = '0;
		{INTERNAL_REFERENCE_LEVEL_SELECT_I, XFER_START_I, XFER_CRC_I, XFER_STAT_I, XFER_SIZE_I} = '0;
		{READY_ON_PIN_I, READY_N_I, ERR_CHECK_REQ_I, rsts} = '0;
		{XFER_READ_I, TX_BIT_I, RESERVED_WR_I} = 3'h7;
		repeat (2) @(posedge CLK_SYS_I);
		NRST_I <= 1'b1;
		@(posedge CLK_SYS_I);
		cmp("select enable", 8'h00, 8'(CHIP_SELECT_PIN_ENABLE_O));
		cmp("ref enable", 8'h00, 8'(INTERNAL_REFERENCE_ENABLE_O));
		cfg(0, 0, 1, 1);
		cmp("ref pin on", 8'h01, 8'(REFERENCE_OUTPUT_PIN_O));
		cmp("reserved", 8'h00, 8'(RESERVED_O));
		cfg(0, 0, 0, 1);
		cmp("ref pin off", 8'h00, 8'(REFERENCE_OUTPUT_PIN_O));
		cmp("ref select", 8'h01, 8'(INTERNAL_REFERENCE_LEVEL_SELECT_O));
		host_u.sel(1'b0);
		for (int i = 0; i < 4; i++) begin
			read3((i < 3) ? 2'(i) : 2'h2, i == 3, (i == 3) ? 40 : 8 * (i + 1));
			cmp("oe after read", 8'h00, 8'(DOUT_OE_O));
		end
		h0 = held;
		cfg(0, 1, 0, 0);
		read3(0, 0, 8);
		cmp("release delay", 8'(SWM_REL_DELAY_CYC), 8'(held - h0));
		XFER_READ_I <= 1'b0;
		read3(0, 0, 8);
		cmp("oe in write", 8'h00, 8'(held));
		XFER_READ_I <= 1'b1;
		@(posedge CLK_SYS_I);
		{READY_ON_PIN_I, READY_N_I, ERR_CHECK_REQ_I} <= 3'h7;
		cfg(0, 0, 0, 0);
		read3(1, 0, 16);
		cmp("ready oe", 8'h01, 8'(DOUT_OE_O));
		cmp("ready level", 8'h01, 8'(DOUT_O));
		cmp("check 3-wire", 8'h00, 8'(SERIAL_CLOCK_COUNT_ERROR_CHECK_O));
		host_u.sel(1'b1);
		repeat (8) @(posedge CLK_SYS_I);
		cmp("oe select high", 8'h00, 8'(DOUT_OE_O));
		cfg(1, 0, 0, 0);
		cmp("select enable", 8'h01, 8'(CHIP_SELECT_PIN_ENABLE_O));
		cmp("check 4-wire", 8'h01, 8'(SERIAL_CLOCK_COUNT_ERROR_CHECK_O));
		host_u.sel(1'b0);
		TX_BIT_I <= 1'b0;
		start(0, 0);
		r0 = rsts;
		host_u.bits(8);
		#400;
		cmp("end before rise", 8'h00, 8'(rsts - r0));
		cmp("oe before rise", 8'h01, 8'(DOUT_OE_O));
		cmp("data before rise", 8'h00, 8'(DOUT_O));
		cmp("busy before rise", 8'h01, 8'(BUSY_O));
		host_u.sel(1'b1);
		repeat (8) @(posedge CLK_SYS_I);
		cmp("end on rise", 8'h01, 8'(rsts - r0));
		cmp("oe after rise", 8'h00, 8'(DOUT_OE_O));
		cmp("busy after rise", 8'h00, 8'(BUSY_O));
		READY_N_I <= 1'b0;
		host_u.sel(1'b0);
		repeat (8) @(posedge CLK_SYS_I);
		cmp("ready after rise", 8'h02, 8'({DOUT_OE_O, DOUT_O}));
		complete_run();
	end
	initial begin
		#200000;
		mismatches++;
		complete_run();
	end
endmodule // swm_spi_mode_tb
`default_nettype wire
